// ==== acrs_host.sv ====
// Controller that triggers a chain of serial converters and receives
// their frames from the link output of the last device.
// Assumes the devices make the link clock and that sync and data are
// sampled on its rising edge; all control pins are system clocked.
//
// Notes on behaviour
// - Daisy period exceeds startup plus n frames.
// - One shared trigger gives identical conversion rates.
// - Last busy loops back to head read request.
// - Recovery: chip select high 20 ns, then low.
// - One chip select drives all devices together.
// - Sync every 16 clocks; latch two edges later.
// - Cascade: only head drives the link clock.
// - Cascade: external link clock recommended for all; the code has the head drive it instead.
// - Cascade period exceeds head plus follower reads.
// - At most four devices on a cascade bus.
// - Topology pin low daisy, high cascade.
`default_nettype none

module acrs_host #(
    parameter int MAX_DEVICES = 4,
    parameter int LINK_PERIOD_NS = 5,
    parameter int DEV_DELAY_NS = 0,
    parameter int SYNC_DLY_NS = 0,
    parameter int POST_NS = 0
) (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic run_in,
    input wire logic halt_in,
    input wire logic clear_error_in,
    input wire logic topology_in,
    input wire logic half_frame_in,
    input wire logic [$clog2(MAX_DEVICES+1)-1:0] num_devices_in,
    input wire logic [acrs_pkg::CNT_W-1:0] period_in,
    input wire logic [$clog2(MAX_DEVICES)-1:0] rd_addr_in,
    input wire logic link_clk_in,
    input wire logic sync_in,
    input wire logic serial_data_in,
    output logic conversion_trigger_n_out,
    output logic chip_select_n_out,
    output logic topology_out,
    output logic half_frame_out,
    output logic [MAX_DEVICES-1:0] clock_output_config_p_out,
    output logic [MAX_DEVICES-1:0] clock_output_config_n_out,
    output logic busy_out,
    output logic word_valid_out,
    output logic [acrs_pkg::WORD_W-1:0] word_out,
    output logic [$clog2(MAX_DEVICES)-1:0] word_index_out,
    output logic seq_error_out,
    output logic [acrs_pkg::WORD_W-1:0] rd_data_out
);

    localparam int NDEV_W = $clog2(MAX_DEVICES + 1);
    localparam int AW = $clog2(MAX_DEVICES);
    localparam int CW = acrs_pkg::CNT_W;

    // Least conversion period in ns for n devices in the chosen topology.
    function automatic int min_period_ns(input logic topo, input int n);
        int frame;
        int start1;
        int startn;
        frame = acrs_pkg::FRAME_CLKS * LINK_PERIOD_NS;
        start1 = acrs_pkg::READ_START_NS + DEV_DELAY_NS
            + acrs_pkg::STARTUP_CLKS * LINK_PERIOD_NS;
        startn = SYNC_DLY_NS + acrs_pkg::STARTUP_CLKS * LINK_PERIOD_NS;
        if (topo == acrs_pkg::TOPO_DAISY) begin
            min_period_ns = start1 + n * frame + POST_NS;
        end else begin
            min_period_ns = start1 + frame + POST_NS
                + (n - 1) * (startn + frame + POST_NS);
        end
    endfunction

    // The period must exceed the budget strictly, hence the extra cycle.
    function automatic logic [CW-1:0] min_period_cyc(input logic topo,
                                                     input int n);
        min_period_cyc = CW'((min_period_ns(topo, n)
            * acrs_pkg::SYS_CLK_MHZ) / acrs_pkg::NS_PER_US + 1);
    endfunction

    // System domain state.
    typedef struct packed {
        acrs_pkg::acrs_state_e state;
        logic [CW-1:0] cnt;
        logic [CW-1:0] period;
        logic topo;
        logic half;
        logic [NDEV_W-1:0] ndev;
        logic [MAX_DEVICES-1:0] cfg_p;
        logic [MAX_DEVICES-1:0] cfg_n;
        logic trig_n;
        logic cs_n;
        logic started;
        logic [NDEV_W-1:0] words;
        logic tog_s1;
        logic tog_s2;
        logic tog_s3;
        logic word_valid;
        logic [acrs_pkg::WORD_W-1:0] word;
        logic [AW-1:0] index;
        logic we;
        logic seq_error;
        logic busy;
    } acrs_sys_s;

    // Link domain state.
    typedef struct packed {
        logic sync_s1;
        logic sync_s2;
        logic sync_d;
        logic data_s1;
        logic data_s2;
        logic half_s1;
        logic half_s2;
        logic [acrs_pkg::WORD_W-1:0] shreg;
        logic [acrs_pkg::LCNT_W-1:0] cnt;
        logic [1:0] lat;
        logic [acrs_pkg::WORD_W-1:0] hold;
        logic tog;
    } acrs_lnk_s;

    acrs_sys_s s;
    acrs_sys_s next_s;
    acrs_lnk_s l;
    acrs_lnk_s next_l;
    logic lnk_rst_s1;
    logic lnk_rst;
    // Clamped device count for the requested topology.
    logic [NDEV_W-1:0] req_ndev;
    logic [CW-1:0] req_min;
    // Cascade buses take at most four devices; zero means one.
    always_comb begin
        req_ndev = num_devices_in;
        if (num_devices_in == '0) begin
            req_ndev = NDEV_W'(1);
        end
        if ((topology_in == acrs_pkg::TOPO_CASCADE)
                && (int'(req_ndev) > acrs_pkg::MAX_CASCADE)) begin
            req_ndev = NDEV_W'(acrs_pkg::MAX_CASCADE);
        end
        req_min = min_period_cyc(topology_in, int'(req_ndev));
    end

    // System side sequencer and word collection.
    always_comb begin
        next_s = s;
        next_s.word_valid = 1'b0;
        next_s.we = 1'b0;
        // Toggle from the link domain, two flops before use.
        next_s.tog_s1 = l.tog;
        next_s.tog_s2 = s.tog_s1;
        next_s.tog_s3 = s.tog_s2;
        // The held word stays put for a whole frame, so it is safe here.
        if (s.tog_s2 != s.tog_s3) begin
            next_s.word = l.hold;
            next_s.word_valid = 1'b1;
            next_s.index = AW'(s.words);
            next_s.we = (s.words < s.ndev);
            if (s.words != '1) begin
                next_s.words = s.words + NDEV_W'(1);
            end
        end
        // The clear loses to a new error in the same cycle.
        if (clear_error_in) begin
            next_s.seq_error = 1'b0;
        end
        case (s.state)
            acrs_pkg::ACRS_IDLE: begin
                next_s.cs_n = 1'b1;
                next_s.trig_n = 1'b1;
                if (run_in && !halt_in) begin
                    // Configuration is taken only here, never mid-run.
                    next_s.topo = topology_in;
                    next_s.half = half_frame_in;
                    next_s.ndev = req_ndev;
                    next_s.period = (period_in > req_min) ? period_in
                                                          : req_min;
                    for (int i = 0; i < MAX_DEVICES; i++) begin
                        // Cascade followers keep their clock driver off.
                        if ((i != 0) && topology_in) begin
                            next_s.cfg_p[i] = acrs_pkg::CLKCFG_P_OFF;
                            next_s.cfg_n[i] = acrs_pkg::CLKCFG_N_OFF;
                        end else begin
                            next_s.cfg_p[i] = acrs_pkg::CLKCFG_P_DRIVE;
                            next_s.cfg_n[i] = acrs_pkg::CLKCFG_N_DRIVE;
                        end
                    end
                    // Chip select drops before the first conversion ends.
                    next_s.cs_n = 1'b0;
                    next_s.started = 1'b0;
                    next_s.cnt = '0;
                    next_s.state = acrs_pkg::ACRS_WAIT;
                end
            end
            acrs_pkg::ACRS_TRIG: begin
                next_s.cnt = s.cnt + CW'(1);
                if (s.cnt + CW'(1) >= CW'(acrs_pkg::TRIG_LOW_CYC)) begin
                    next_s.trig_n = 1'b1;
                    next_s.cnt = CW'(1);
                    next_s.state = acrs_pkg::ACRS_WAIT;
                end
            end
            acrs_pkg::ACRS_WAIT: begin
                next_s.cnt = s.cnt + CW'(1);
                if (halt_in) begin
                    // Every device sees the same chip select level.
                    next_s.cs_n = 1'b1;
                    next_s.cnt = '0;
                    next_s.state = acrs_pkg::ACRS_HALT;
                end else if ((s.cnt + CW'(1) >= s.period) || !s.started) begin
                    if (run_in) begin
                        // A short sequence means the period was too tight.
                        if (s.started && (s.words != s.ndev)) begin
                            next_s.seq_error = 1'b1;
                        end
                        next_s.words = '0;
                        next_s.started = 1'b1;
                        // One trigger pin for all devices.
                        next_s.trig_n = 1'b0;
                        next_s.cnt = '0;
                        next_s.state = acrs_pkg::ACRS_TRIG;
                    end else begin
                        next_s.state = acrs_pkg::ACRS_IDLE;
                    end
                end
            end
            acrs_pkg::ACRS_HALT: begin
                next_s.cs_n = 1'b1;
                next_s.trig_n = 1'b1;
                if (s.cnt != '1) begin
                    next_s.cnt = s.cnt + CW'(1);
                end
                // Hold high for the least width, then restart from idle.
                if ((s.cnt + CW'(1) >= CW'(acrs_pkg::CS_HIGH_CYC))
                        && !halt_in) begin
                    next_s.state = acrs_pkg::ACRS_IDLE;
                end
            end
            default: begin
                next_s.state = acrs_pkg::ACRS_IDLE;
            end
        endcase
        next_s.busy = (next_s.state != acrs_pkg::ACRS_IDLE); // Registered.
    end

    // System state register.
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s <= '0;
            s.state <= acrs_pkg::ACRS_IDLE;
            s.trig_n <= 1'b1;
            s.cs_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Reset release is resynchronised to the link clock.
    always_ff @(posedge link_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            lnk_rst_s1 <= 1'b1;
            lnk_rst <= 1'b1;
        end else begin
            lnk_rst_s1 <= 1'b0;
            lnk_rst <= lnk_rst_s1;
        end
    end

    // Link side deserializer; sync and data share the same pipeline.
    always_comb begin
        next_l = l;
        next_l.sync_s1 = sync_in;
        next_l.sync_s2 = l.sync_s1;
        next_l.sync_d = l.sync_s2;
        next_l.data_s1 = serial_data_in;
        next_l.data_s2 = l.data_s1;
        next_l.half_s1 = s.half;
        next_l.half_s2 = l.half_s1;
        next_l.shreg = {l.shreg[acrs_pkg::WORD_W-2:0], l.data_s2};
        if (l.cnt != '1) begin
            next_l.cnt = l.cnt + acrs_pkg::LCNT_W'(1);
        end
        // LSB arrives one edge after the closing sync rise.
        if (l.lat != 2'h0) begin
            next_l.lat = l.lat - 2'h1;
            if (l.lat == 2'h1) begin
                next_l.hold = {l.shreg[acrs_pkg::WORD_W-2:0], l.data_s2};
                next_l.tog = ~l.tog;
            end
        end
        if (l.sync_s2 && !l.sync_d) begin
            if (l.cnt == acrs_pkg::LCNT_W'(acrs_pkg::FRAME_CLKS)) begin
                // Closing rise: latch two edges later, also opens next.
                next_l.lat = 2'(acrs_pkg::LATCH_CLKS - 1);
                next_l.cnt = acrs_pkg::LCNT_W'(1);
            end else if (l.half_s2 && (l.cnt ==
                    acrs_pkg::LCNT_W'(acrs_pkg::HALF_FRAME_CLKS))) begin
                // Mid-word sync of half-frame mode is not a frame edge.
                next_l.cnt = l.cnt + acrs_pkg::LCNT_W'(1);
            end else begin
                next_l.cnt = acrs_pkg::LCNT_W'(1);
            end
        end
    end

    // Link state register.
    always_ff @(posedge link_clk_in or posedge lnk_rst) begin
        if (lnk_rst) begin
            l <= '0;
            l.cnt <= '1;
        end else begin
            l <= next_l;
        end
    end

    // Results of the latest sequence, one word per device.
    acrs_result_mem #(
        .WIDTH(acrs_pkg::WORD_W),
        .DEPTH(MAX_DEVICES),
        .AW(AW)
    ) u_mem (
        .clk_in(sys_clk_in),
        .rst_in(sys_rst_in),
        .wr_en_in(s.we),
        .wr_addr_in(s.index),
        .wr_data_in(s.word),
        .rd_addr_in(rd_addr_in),
        .rd_data_out(rd_data_out)
    );

    assign conversion_trigger_n_out = s.trig_n;
    assign chip_select_n_out = s.cs_n;
    assign topology_out = s.topo;
    assign half_frame_out = s.half;
    assign clock_output_config_p_out = s.cfg_p;
    assign clock_output_config_n_out = s.cfg_n;
    assign busy_out = s.busy;
    assign word_valid_out = s.word_valid;
    assign word_out = s.word;
    assign word_index_out = s.index;
    assign seq_error_out = s.seq_error;

endmodule

`default_nettype wire

// ==== acrs_pkg.sv ====
// Shared constants for the converter chain readout sequencer.
// Assumes a 10 MHz system clock and a link clock made by the converters.
`default_nettype none

package acrs_pkg;

    // System clock rate, used to turn times into cycle counts.
    localparam int SYS_CLK_MHZ = 10;
    localparam int NS_PER_US = 1000;

    // Least width of the chip-select high pulse that clears a halt.
    localparam int CS_HIGH_MIN_NS = 20;
    // A least time rounds up, and never comes to less than one cycle.
    localparam int CS_HIGH_CYC_RAW =
        (CS_HIGH_MIN_NS * SYS_CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    localparam int CS_HIGH_CYC = (CS_HIGH_CYC_RAW < 1) ? 1 : CS_HIGH_CYC_RAW;

    // Fixed part of the head device read startup delay.
    localparam int READ_START_NS = 10;

    // Link clocks per frame sync period, full and half frame.
    localparam int FRAME_CLKS = 16;
    localparam int HALF_FRAME_CLKS = 8;
    // Link clocks between a read start and the first data bit.
    localparam int STARTUP_CLKS = 2;
    // Word is latched on the second rising edge after a sync rise.
    localparam int LATCH_CLKS = 2;
    // Converted word width.
    localparam int WORD_W = 16;
    // Most devices allowed on one shared cascade bus.
    localparam int MAX_CASCADE = 4;

    // Width of the system side counters.
    localparam int CNT_W = 16;
    // Width of the link side edge counter; it saturates at all ones.
    localparam int LCNT_W = 5;

    // Cycles that the conversion trigger is held low.
    localparam int TRIG_LOW_CYC = 1;

    // Topology select pin levels.
    localparam logic TOPO_DAISY = 1'b0;
    localparam logic TOPO_CASCADE = 1'b1;

    // Clock output configuration pin levels per device.
    localparam logic CLKCFG_P_DRIVE = 1'b1;
    localparam logic CLKCFG_N_DRIVE = 1'b0;
    localparam logic CLKCFG_P_OFF = 1'b0;
    localparam logic CLKCFG_N_OFF = 1'b0;

    // Sequencer states, one-hot.
    typedef enum logic [3:0] {
        ACRS_IDLE = 4'h1,
        ACRS_TRIG = 4'h2,
        ACRS_WAIT = 4'h4,
        ACRS_HALT = 4'h8
    } acrs_state_e;

endpackage

`default_nettype wire

// ==== acrs_result_mem.sv ====
// Small result store: one word per device of the last read sequence.
// Assumes write and read come from the system clock domain.
`default_nettype none

module acrs_result_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4,
    parameter int AW = 2
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic [AW-1:0] rd_addr_in,
    output logic [WIDTH-1:0] rd_data_out
);

    // Storage and the read register live in one packed state.
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0] rd;
    } acrs_mem_s;

    acrs_mem_s s;
    acrs_mem_s next_s;

    // Write and read; the read data come out a cycle later.
    always_comb begin
        next_s = s;
        if (wr_en_in && (int'(wr_addr_in) < DEPTH)) begin
            next_s.mem[wr_addr_in] = wr_data_in;
        end
        // An address past the depth reads as zero.
        if (int'(rd_addr_in) < DEPTH) begin
            next_s.rd = s.mem[rd_addr_in];
        end else begin
            next_s.rd = '0;
        end
    end

    // State register.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rd_data_out = s.rd;

endmodule

`default_nettype wire

// ==== acrs_host_sva.sv ====
// Checker for the sequencer's pins, bound into each sequencer instance.
// Assumes one system clock domain with an active high reset.
`default_nettype none

module acrs_host_sva #(
    parameter int MAX_DEVICES = 4
) (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic run_in,
    input wire logic halt_in,
    input wire logic topology_in,
    input wire logic conversion_trigger_n_out,
    input wire logic chip_select_n_out,
    input wire logic topology_out,
    input wire logic [MAX_DEVICES-1:0] clock_output_config_p_out,
    input wire logic [MAX_DEVICES-1:0] clock_output_config_n_out,
    input wire logic busy_out,
    input wire logic word_valid_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking dc @(posedge sys_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    // An idle sequencer that is told to run.
    sequence s_take;
        !busy_out && run_in && !halt_in;
    endsequence
    // Chip select low with the topology pin latched, then the trigger pulse.
    sequence s_launch;
        !chip_select_n_out && busy_out && topology_out == $past(topology_in)
            ##1 !conversion_trigger_n_out;
    endsequence

    chk_start_walk: assert property (
        s_take |=> s_launch)
        else $error("launch from idle out of order");
    chk_trig_pulse: assert property (
        $fell(conversion_trigger_n_out) |=> conversion_trigger_n_out)
        else $error("trigger held low too long");
    chk_trig_busy: assert property (
        !conversion_trigger_n_out |-> busy_out && !chip_select_n_out)
        else $error("trigger outside a selected sequence");
    chk_halt_cs: assert property (
        halt_in [*3] |-> chip_select_n_out)
        else $error("chip select low during halt");
    // A chip select high pulse must outlast one cycle so the devices see 20 ns.
    chk_cs_width: assert property (
        $rose(chip_select_n_out) && busy_out |=> chip_select_n_out)
        else $error("chip select high pulse too short");
    chk_idle_cs: assert property (
        !busy_out && !run_in |=> chip_select_n_out)
        else $error("chip select low while idle");
    chk_cfg_pins: assert property (
        busy_out |-> clock_output_config_n_out == '0 &&
        clock_output_config_p_out ==
        (topology_out ? MAX_DEVICES'(1) : {MAX_DEVICES{1'b1}}))
        else $error("clock output configuration wrong");
    chk_valid_pulse: assert property (
        word_valid_out |=> !word_valid_out)
        else $error("word valid longer than one cycle");
endmodule

bind acrs_host acrs_host_sva #(.MAX_DEVICES(MAX_DEVICES)) acrs_host_sva_i (
    .sys_clk_in, .sys_rst_in, .run_in, .halt_in, .topology_in,
    .conversion_trigger_n_out, .chip_select_n_out, .topology_out,
    .clock_output_config_p_out, .clock_output_config_n_out,
    .busy_out, .word_valid_out
);

`default_nettype wire

// ==== acrs_dev_model.sv ====
// Behavioural chain of serial converters as seen at the last link output.
// Assumes one shared trigger and chip select; the link clock is made
// here and stands still outside read sequences and the power-up burst.
`default_nettype none

module acrs_dev_model #(
    parameter int CONV_NS = 213, // Off grid, so link edges miss system edges.
    parameter int HALF_NS = 15
) (
    input wire logic trig_n_in,
    input wire logic cs_n_in,
    input wire logic topo_in,
    input wire logic half_in,
    input wire logic en_in,
    input wire logic [2:0] ndev_in,
    output logic link_clk_out,
    output logic sync_out,
    output logic sdata_out
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0; // Conversions started since power-up.
    logic [15:0] val [4]; // Latest result of each device, four at most.

    // A short clock burst at power-up lets the receiver leave reset.
    initial begin
        link_clk_out = 1'b0;
        sync_out = 1'b0; // Bus idle and token low after power-up.
        sdata_out = 1'b0;
        repeat (8) begin
            #HALF_NS link_clk_out = 1'b1;
            #HALF_NS link_clk_out = 1'b0;
        end
    end

    // Slot k holds the token; the busy ripple reduces to a slot index.
    task automatic drive(input int e, input int gap);
        int k;
        int r;
        k = e / gap;
        if (k > ndev_in - 1)
            k = ndev_in - 1;
        r = e - k * gap;
        // Sync rises at the opening and sixteenth edge.
        sync_out = (r < 18) && ((r % (half_in ? 8 : 16)) < 4);
        if (r >= 2 && r < 18)
            sdata_out = val[k][17 - r];
        else if (r < 2 && k > 0 && !topo_in)
            sdata_out = val[k - 1][1 - r]; // Upstream tail.
        else
            sdata_out = ~sdata_out; // Released line.
    endtask

    // Clocks out one read sequence; a halt stops it at once.
    task automatic read_seq();
        int gap;
        gap = topo_in ? 20 : 16;
        for (int e = 0; e < (ndev_in - 1) * gap + 22; e++) begin
            link_clk_out = 1'b1;
            #1;
            if (cs_n_in)
                break;
            drive(e, gap);
            #(HALF_NS - 1) link_clk_out = 1'b0;
            #HALF_NS;
        end
        // Failsafe receivers see a released sync line as low.
        link_clk_out = 1'b0;
        sync_out = 1'b0;
    endtask

    // The trigger samples every device; reading starts at conversion end.
    always @(negedge trig_n_in) begin
        cnt++;
        for (int k = 0; k < 4; k++)
            val[k] = 16'h8001 | 16'(k << 8) | 16'((cnt % 16) << 4);
        #CONV_NS;
        if (en_in && !cs_n_in)
            read_seq();
    end
endmodule

`default_nettype wire

// ==== acrs_host_test.sv ====
// Self-checking bench for the readout sequencer and a model chain.
// Assumes the model makes a 30 ns link clock only while reading and at power-up.
`default_nettype none

module acrs_host_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LINK_NS = 30;
    logic sys_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic run_in = 1'b0;
    logic halt_in = 1'b0;
    logic clear_error_in = 1'b0;
    logic topology_in = 1'b0;
    logic half_frame_in = 1'b0;
    logic [2:0] num_devices_in = 3'h1;
    logic [15:0] period_in = 16'h003c;
    logic [1:0] rd_addr_in = 2'h0;
    logic model_en = 1'b1;
    logic link_clk_in, sync_in, serial_data_in;
    logic conversion_trigger_n_out, chip_select_n_out, topology_out;
    logic half_frame_out, busy_out, word_valid_out, seq_error_out;
    logic [3:0] clock_output_config_p_out, clock_output_config_n_out;
    logic [15:0] word_out, rd_data_out;
    logic [1:0] word_index_out;
    int err_count = 0;
    int n_checks = 0;
    int trig_count = 0; // Trigger pulses seen so far.
    logic [15:0] q_word [$];
    logic [1:0] q_idx [$];
    int q_tc [$];

    acrs_host #(.LINK_PERIOD_NS(LINK_NS)) acrs_host_i (
        .sys_clk_in, .sys_rst_in, .run_in, .halt_in, .clear_error_in,
        .topology_in, .half_frame_in, .num_devices_in, .period_in,
        .rd_addr_in, .link_clk_in, .sync_in, .serial_data_in,
        .conversion_trigger_n_out, .chip_select_n_out, .topology_out,
        .half_frame_out, .clock_output_config_p_out,
        .clock_output_config_n_out, .busy_out, .word_valid_out, .word_out,
        .word_index_out, .seq_error_out, .rd_data_out
    );
    acrs_dev_model acrs_dev_model_i (
        .trig_n_in(conversion_trigger_n_out), .cs_n_in(chip_select_n_out),
        .topo_in(topology_out), .half_in(half_frame_out), .en_in(model_en),
        .ndev_in(num_devices_in), .link_clk_out(link_clk_in),
        .sync_out(sync_in), .sdata_out(serial_data_in)
    );

    initial begin
        forever #50 sys_clk_in = ~sys_clk_in;
    end

    // Words are logged mid-cycle, away from the register updates.
    always @(negedge conversion_trigger_n_out) trig_count++;
    always @(negedge sys_clk_in) begin
        if (word_valid_out === 1'b1) begin
            q_word.push_back(word_out);
            q_idx.push_back(word_index_out);
            q_tc.push_back(trig_count);
        end
    end

    function automatic logic [15:0] ew(input int k, input int tc);
        return 16'h8001 | 16'(k << 8) | 16'((tc % 16) << 4);
    endfunction

    task automatic step();
        @(posedge sys_clk_in);
        #5;
    endtask

    task automatic chk_val(input string nm, input logic [15:0] e,
                           input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        chk_val(nm, {15'h0, e}, {15'h0, g});
    endtask

    task automatic clear_q();
        q_word.delete();
        q_idx.delete();
        q_tc.delete();
    endtask

    task automatic wait_words(input int n);
        for (int w = 0; w < 500 && q_word.size() < n; w++)
            step();
    endtask

    task automatic wait_idle();
        for (int w = 0; w < 200 && busy_out !== 1'b0; w++)
            step();
    endtask

    task automatic trig_gap(output int g);
        g = 0;
        do begin
            step();
            g++;
        end while (conversion_trigger_n_out !== 1'b0 && g < 100);
    endtask

    // Runs whole sequences and checks words, pins and stored results.
    task automatic run_seq(input logic topo, input logic half, input int n,
                           input int seqs);
        clear_q();
        topology_in = topo;
        half_frame_in = half;
        num_devices_in = 3'(n);
        run_in = 1'b1;
        wait_words(n * seqs);
        chk_bit("topology pin", topo, topology_out);
        chk_bit("half frame pin", half, half_frame_out);
        chk_val("clock config", topo ? 16'h1 : 16'hf,
                16'(clock_output_config_p_out));
        run_in = 1'b0;
        chk_val("word count", 16'(n * seqs), 16'(q_word.size()));
        for (int i = 0; i < q_word.size(); i++) begin
            chk_val("word", ew(i % n, q_tc[i]), q_word[i]);
            chk_val("index", 16'(i % n), 16'(q_idx[i]));
        end
        wait_idle();
        chk_bit("sequence error", 1'b0, seq_error_out);
        for (int k = 0; k < n; k++) begin
            rd_addr_in = 2'(k);
            step();
            step();
            chk_val("stored", ew(k, q_tc[n * seqs - 1]), rd_data_out);
        end
    endtask

    task automatic conclude();
        $display("checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // The tests need about 40 us; a hang is cut off well beyond that.
    initial begin
        #400000;
        err_count++;
        conclude();
    end

    initial begin
        int g;
        repeat (2) @(posedge sys_clk_in);
        #5;
        sys_rst_in = 1'b0;
        chk_bit("trigger idle", 1'b1, conversion_trigger_n_out);
        chk_bit("busy idle", 1'b0, busy_out);
        step();
        run_seq(1'b0, 1'b0, 2, 2);
        $display("daisy chain test done");
        run_seq(1'b1, 1'b0, 4, 1);
        $display("cascade test done");
        run_seq(1'b0, 1'b1, 1, 1);
        $display("half frame test done");
        // A halt in mid-read, then a fresh sequence after recovery.
        clear_q();
        topology_in = 1'b0;
        half_frame_in = 1'b0;
        num_devices_in = 3'h2;
        run_in = 1'b1;
        wait_words(1);
        halt_in = 1'b1;
        step();
        step();
        chk_bit("halt select", 1'b1, chip_select_n_out);
        repeat (3) step(); // Words of the cut sequence drain first.
        halt_in = 1'b0;
        clear_q();
        wait_words(2);
        run_in = 1'b0;
        chk_val("word after halt", ew(0, q_tc[0]), q_word[0]);
        chk_val("word after halt", ew(1, q_tc[1]), q_word[1]);
        wait_idle();
        $display("halt test done");
        // A too short period is raised; a silent chain flags an error.
        model_en = 1'b0;
        period_in = 16'h0001;
        num_devices_in = 3'h0;
        run_in = 1'b1;
        trig_gap(g);
        trig_gap(g);
        chk_val("trigger gap", 16'((10 + 18 * LINK_NS) * 10 / 1000 + 1),
                16'(g));
        step();
        chk_bit("error flag", 1'b1, seq_error_out);
        run_in = 1'b0;
        wait_idle();
        clear_error_in = 1'b1;
        step();
        clear_error_in = 1'b0;
        step();
        chk_bit("error cleared", 1'b0, seq_error_out);
        $display("period test done");
        conclude();
    end
endmodule

`default_nettype wire
